// ===== mlc_pkg.sv
// package of offsets, fields and carriers for the message-list counter block
package mlc_pkg;
  localparam logic [11:0] MLC_OFS_OUT_POST = 12'h134;
  localparam logic [11:0] MLC_OFS_IN_POST = 12'h138;
  localparam logic [11:0] MLC_OFS_CTRL = 12'h13c;
  localparam logic [7:0] MLC_PORT_IN = 8'h40;
  localparam logic [7:0] MLC_PORT_OUT = 8'h44;
  localparam int MLC_CNT_W = 16;
  localparam int MLC_LOAD_BIT = 31;
  localparam int MLC_CTRL_INIT_BIT = 0;
  localparam int MLC_CTRL_SERR_BIT = 1;
  localparam int MLC_CTRL_RSERR_BIT = 3;
  localparam int MLC_CMD_SERR_EN_BIT = 8;
  localparam logic [15:0] MLC_CNT_RST = 16'h0000;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mlc_bus_req_t;

  typedef struct packed {
    logic [7:0] port;
    logic rd;
    logic wr;
  } mlc_pci_acc_t;

  typedef enum logic [1:0] {
    MLC_CNT_HOLD = 2'b00,
    MLC_CNT_INC = 2'b01,
    MLC_CNT_DEC = 2'b10,
    MLC_CNT_LOAD = 2'b11
  } mlc_cnt_op_t;
endpackage : mlc_pkg

// ===== mlc_counter.sv
// one 16-bit list counter with processor action and pci adjustment
`timescale 1ns/1ps
module mlc_counter
  import mlc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire mlc_cnt_op_t i_cpu_op,
  input wire logic [15:0] i_load_val,
  input wire logic i_pci_inc,
  input wire logic i_pci_dec,
  output logic [15:0] o_count
);
  logic [15:0] base;
  logic [15:0] pci_adj;

  always_comb begin
    case (i_cpu_op)
      MLC_CNT_INC: base = o_count + 16'h0001;
      MLC_CNT_DEC: base = o_count - 16'h0001;
      MLC_CNT_LOAD: base = i_load_val;
      default: base = o_count;
    endcase
    // pci step applied on top of processor action
    if (i_pci_inc && !i_pci_dec) begin
      pci_adj = 16'h0001;
    end else if (i_pci_dec && !i_pci_inc) begin
      pci_adj = 16'hffff;
    end else begin
      pci_adj = 16'h0000;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_count <= MLC_CNT_RST;
    end else begin
      o_count <= base + pci_adj;
    end
  end
endmodule : mlc_counter

// ===== mlc_top.sv
// message-list counters and low processor control bits
`timescale 1ns/1ps
// Behaviour
// - processor write to outbound count increments it when bit 31 is clear, loads it when set.
// - each pci read of port 44h decrements the outbound count.
// - pci interrupt is asserted while outbound count is nonzero unless masked.
// - each pci write of port 40h increments the inbound count.
// - processor write to inbound count decrements it when bit 31 is clear, loads it when set.
// - processor interrupt is posted while inbound count is nonzero, per the two enable masks.
// - both counts are 16 bits, reset to zero, upper bits read zero.
// - while init-complete is clear, config cycles and io or memory claims are refused.
// - once init-complete is set, config cycles answer normally; it resets to zero.
// - assert-serr bit drives system error when central strap is off and command bit 8 is set.
// - received-serr is set by external serr while central strap is on, cleared by writing 1.
module mlc_top
  import mlc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_pci_port_rd,
  input wire logic i_pci_port_wr,
  input wire logic [7:0] i_pci_port_addr,
  input wire logic i_out_irq_mask,
  input wire logic i_normal_irq_enable_reg,
  input wire logic i_fast_irq_enable_reg,
  input wire logic i_normal_rserr_enable,
  input wire logic i_fast_rserr_enable,
  input wire logic i_cmd_reg_bit8,
  input wire logic i_central_fn,
  input wire logic i_serr_n,
  output logic o_pci_irq_n,
  output logic o_cpu_irq,
  output logic o_cpu_fiq,
  output logic o_cpu_rserr_irq,
  output logic o_cpu_rserr_fiq,
  output logic o_target_enable,
  output logic o_serr_n_out,
  output logic o_serr_n_oe
);
  // ----------------------------------------------------------------
  // request carriers and decode
  // ----------------------------------------------------------------
  mlc_bus_req_t req;
  mlc_pci_acc_t pci;
  logic [15:0] out_count;
  logic [15:0] in_count;
  logic init_done;
  logic assert_serr;
  logic rx_serr;
  logic strap_s1, strap_s2;
  logic serr_s1, serr_s2;
  mlc_cnt_op_t out_op;
  mlc_cnt_op_t in_op;
  logic pci_out_rd;
  logic pci_in_wr;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign pci = '{port: i_pci_port_addr, rd: i_pci_port_rd, wr: i_pci_port_wr};

  function automatic mlc_cnt_op_t cpu_op(input logic hit, input logic load,
                                         input mlc_cnt_op_t step);
    if (!hit) begin
      cpu_op = MLC_CNT_HOLD;
    end else if (load) begin
      cpu_op = MLC_CNT_LOAD;
    end else begin
      cpu_op = step;
    end
  endfunction : cpu_op

  assign out_op = cpu_op(req.wr && req.addr == MLC_OFS_OUT_POST,
                         req.wdata[MLC_LOAD_BIT], MLC_CNT_INC);
  assign in_op = cpu_op(req.wr && req.addr == MLC_OFS_IN_POST,
                        req.wdata[MLC_LOAD_BIT], MLC_CNT_DEC);
  assign pci_out_rd = pci.rd && pci.port == MLC_PORT_OUT;
  assign pci_in_wr = pci.wr && pci.port == MLC_PORT_IN;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  mlc_counter u_out_cnt (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_cpu_op(out_op),
    .i_load_val(req.wdata[MLC_CNT_W-1:0]),
    .i_pci_inc(1'b0),
    .i_pci_dec(pci_out_rd),
    .o_count(out_count)
  );

  mlc_counter u_in_cnt (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_cpu_op(in_op),
    .i_load_val(req.wdata[MLC_CNT_W-1:0]),
    .i_pci_inc(pci_in_wr),
    .i_pci_dec(1'b0),
    .o_count(in_count)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      serr_s1 <= 1'b1;
      serr_s2 <= 1'b1;
    end else begin
      strap_s1 <= i_central_fn;
      strap_s2 <= strap_s1;
      serr_s1 <= i_serr_n;
      serr_s2 <= serr_s1;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      init_done <= 1'b0;
      assert_serr <= 1'b0;
    end else if (req.wr && req.addr == MLC_OFS_CTRL) begin
      init_done <= req.wdata[MLC_CTRL_INIT_BIT];
      assert_serr <= req.wdata[MLC_CTRL_SERR_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rx_serr <= 1'b0;
    end else if (!serr_s2 && strap_s2) begin
      rx_serr <= 1'b1;
    end else if (req.wr && req.addr == MLC_OFS_CTRL && req.wdata[MLC_CTRL_RSERR_BIT]) begin
      rx_serr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic drive_serr;
  assign drive_serr = assert_serr && !strap_s2 && i_cmd_reg_bit8;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_pci_irq_n <= 1'b1;
      o_cpu_irq <= 1'b0;
      o_cpu_fiq <= 1'b0;
      o_cpu_rserr_irq <= 1'b0;
      o_cpu_rserr_fiq <= 1'b0;
      o_target_enable <= 1'b0;
      o_serr_n_out <= 1'b1;
      o_serr_n_oe <= 1'b1;
    end else begin
      o_pci_irq_n <= !((out_count != 16'h0000) && !i_out_irq_mask);
      o_cpu_irq <= (in_count != 16'h0000) && i_normal_irq_enable_reg;
      o_cpu_fiq <= (in_count != 16'h0000) && i_fast_irq_enable_reg;
      o_cpu_rserr_irq <= rx_serr && i_normal_rserr_enable;
      o_cpu_rserr_fiq <= rx_serr && i_fast_rserr_enable;
      o_target_enable <= init_done;
      o_serr_n_out <= 1'b0;
      o_serr_n_oe <= !drive_serr;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata <= 32'h0000_0000;
    end else if (req.rd) begin
      if (req.addr == MLC_OFS_OUT_POST) begin
        o_rdata <= {16'h0000, out_count};
      end else if (req.addr == MLC_OFS_IN_POST) begin
        o_rdata <= {16'h0000, in_count};
      end else if (req.addr == MLC_OFS_CTRL) begin
        o_rdata <= {28'h000_0000, rx_serr, 1'b0, assert_serr, init_done};
      end else begin
        o_rdata <= 32'h0000_0000;
      end
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end
endmodule : mlc_top

// ===== mlc_top_props.sv
// port checker of the message-list counter block
`timescale 1ns/1ps
module mlc_props
  import mlc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_pci_port_rd,
  input wire logic i_pci_port_wr,
  input wire logic i_out_irq_mask,
  input wire logic i_normal_irq_enable_reg,
  input wire logic i_cmd_reg_bit8,
  input wire logic o_pci_irq_n,
  input wire logic o_cpu_irq,
  input wire logic o_target_enable,
  input wire logic o_serr_n_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  property p_rd_idle; !i_rd |=> o_rdata == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_rd_high; i_rd |=> o_rdata[31:16] == 16'h0000; endproperty
  a_rd_high: assert property (p_rd_high) else $error("upper bits set");
  property p_mask; i_out_irq_mask |=> o_pci_irq_n; endproperty
  a_mask: assert property (p_mask) else $error("masked pci irq");
  property p_ien; !i_normal_irq_enable_reg |=> !o_cpu_irq; endproperty
  a_ien: assert property (p_ien) else $error("disabled cpu irq");
  property p_out_load; i_wr && i_addr == MLC_OFS_OUT_POST && i_wdata[31]
    && i_wdata[15:0] != 16'h0000 && !i_pci_port_rd ##1 !i_out_irq_mask |=> !o_pci_irq_n;
  endproperty
  a_out_load: assert property (p_out_load) else $error("no pci irq");
  property p_in_load; i_wr && i_addr == MLC_OFS_IN_POST && i_wdata[31]
    && i_wdata[15:0] != 16'h0000 && !i_pci_port_wr ##1 i_normal_irq_enable_reg |=> o_cpu_irq;
  endproperty
  a_in_load: assert property (p_in_load) else $error("no cpu irq");
  property p_init; i_wr && i_addr == MLC_OFS_CTRL && i_wdata[0] |-> ##[1:2] o_target_enable;
  endproperty
  a_init: assert property (p_init) else $error("target not enabled");
  property p_serr; !i_cmd_reg_bit8 |=> o_serr_n_oe; endproperty
  a_serr: assert property (p_serr) else $error("serr driven");
endmodule : mlc_props

bind mlc_top mlc_props props (.*);

// ===== mlc_pci_side.sv
// model of the pci masters using the two list ports
`timescale 1ns/1ps
module mlc_pci_side
  import mlc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_get,
  input wire logic i_put,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_addr = 8'h00
);
  // one-cycle access; address wanders while idle
  always_ff @(posedge i_clk) begin
    o_rd <= i_get;
    o_wr <= i_put;
    o_addr <= i_get ? MLC_PORT_OUT : (i_put ? MLC_PORT_IN : ~o_addr);
  end
endmodule : mlc_pci_side

// ===== mlc_top_tb.sv
// self-checking bench of the message-list counter block
`timescale 1ns/1ps
module mlc_top_tb;
  import mlc_pkg::*;
  logic i_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, get = 0, put = 0, mask = 0, ien = 0;
  logic cmd8 = 0, cfn = 0, ext_n = 1, p_rd, p_wr, irq_n, irq, fiq, rs_irq, te, s_out, s_oe;
  logic rs_fiq;
  logic [11:0] i_addr = 12'h000;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [31:0] o_rdata;
  logic [7:0] p_addr;
  int fail_count = 0, num_checks = 0;
  always #5 i_clk = ~i_clk;
  mlc_pci_side far (.i_clk, .i_get(get), .i_put(put), .o_rd(p_rd), .o_wr(p_wr), .o_addr(p_addr));
  mlc_top dut (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_pci_port_rd(p_rd), .i_pci_port_wr(p_wr), .i_pci_port_addr(p_addr), .i_out_irq_mask(mask),
    .i_normal_irq_enable_reg(ien), .i_fast_irq_enable_reg(ien), .i_normal_rserr_enable(1'b1),
    .i_fast_rserr_enable(ien), .i_cmd_reg_bit8(cmd8), .i_central_fn(cfn),
    .i_serr_n(ext_n & (s_oe | s_out)), .o_pci_irq_n(irq_n), .o_cpu_irq(irq), .o_cpu_fiq(fiq),
    .o_cpu_rserr_irq(rs_irq), .o_cpu_rserr_fiq(rs_fiq), .o_target_enable(te), .o_serr_n_out(s_out),
    .o_serr_n_oe(s_oe));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 0;
    @(negedge i_clk);
    chk(o_rdata, e);
  endtask : rd
  task automatic pci(input logic g, input logic p);
    @(posedge i_clk);
    get <= g;
    put <= p;
    @(posedge i_clk);
    get <= 0;
    put <= 0;
  endtask : pci
  task automatic t_reset;
    rd(MLC_OFS_CTRL, 0);
    rd(12'h100, 0);
    chk(te, 0);
  endtask : t_reset
  task automatic t_out;
    rd(MLC_OFS_OUT_POST, 0);
    chk(irq_n, 1);
    wr(MLC_OFS_OUT_POST, 32'h7fff_ffff);
    rd(MLC_OFS_OUT_POST, 1);
    wr(MLC_OFS_OUT_POST, 32'h8abc_0002);
    pci(1, 0);
    rd(MLC_OFS_OUT_POST, 1);
    chk(irq_n, 0);
    @(posedge i_clk);
    mask <= 1;
    rd(MLC_OFS_OUT_POST, 1);
    chk(irq_n, 1);
  endtask : t_out
  task automatic t_in;
    @(posedge i_clk);
    ien <= 1;
    wr(MLC_OFS_IN_POST, 32'h8000_0001);
    pci(0, 1);
    rd(MLC_OFS_IN_POST, 2);
    chk({irq, fiq}, 2'b11);
    wr(MLC_OFS_IN_POST, 32'h7fff_ffff);
    wr(MLC_OFS_IN_POST, 0);
    rd(MLC_OFS_IN_POST, 0);
    chk(irq, 0);
  endtask : t_in
  task automatic t_same;
    fork
      pci(1, 0);
      begin
        @(posedge i_clk);
        wr(MLC_OFS_OUT_POST, 32'h8000_0010);
      end
    join
    rd(MLC_OFS_OUT_POST, 32'h0000_000f);
  endtask : t_same
  task automatic t_ctrl;
    wr(MLC_OFS_CTRL, 32'h0000_0003);
    rd(MLC_OFS_CTRL, 3);
    chk({te, s_oe}, 2'b11);
    @(posedge i_clk);
    cmd8 <= 1;
    rd(MLC_OFS_CTRL, 3);
    chk(s_oe, 0);
    chk(s_out, 0);
    @(posedge i_clk);
    cfn <= 1;
    ext_n <= 0;
    repeat (4) @(posedge i_clk);
    ext_n <= 1;
    rd(MLC_OFS_CTRL, 32'h0000_000b);
    chk({s_oe, rs_irq, rs_fiq}, 3'b111);
    repeat (4) @(posedge i_clk);
    wr(MLC_OFS_CTRL, 32'h0000_000b);
    rd(MLC_OFS_CTRL, 3);
    chk({rs_irq, rs_fiq}, 2'b00);
  endtask : t_ctrl
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial begin
    repeat (8) @(posedge i_clk);
    i_resetn <= 1;
    t_reset();
    t_out();
    t_in();
    t_same();
    t_ctrl();
    complete_run();
  end
endmodule : mlc_top_tb
